// *** can_tx_flags_pkg.sv ***
package can_tx_flags_pkg;
	// register indices: the printed offsets are not multiples of four,
	// so the byte address on the bus is four times the index
	localparam int unsigned ADDR_W          = 6;
	localparam logic [5:0]  IDX_TX_FLAG     = 6'h06;
	localparam logic [5:0]  IDX_TX_IRQ_EN   = 6'h07;
	localparam logic [5:0]  IDX_ABORT_REQ   = 6'h08;
	localparam logic [5:0]  IDX_ABORT_ACK   = 6'h09;
	localparam logic [5:0]  IDX_CTRL        = 6'h0A;
	localparam logic [5:0]  IDX_IRQ_STATUS  = 6'h0B;
	localparam logic [5:0]  IDX_IRQ_MASK    = 6'h0C;
	localparam int unsigned NUM_SLOTS       = 3;
	localparam logic [2:0]  FLAG_RESET      = 3'h7;
	localparam logic [2:0]  IRQ_EN_RESET    = 3'h0;
	localparam logic [2:0]  ZERO3           = 3'h0;
	// control register bit positions
	localparam int unsigned CTRL_INIT_REQ   = 0;
	localparam int unsigned CTRL_LISTEN     = 1;
	localparam int unsigned CTRL_INIT_ACK   = 2;
	// slot-access guard states
	typedef enum logic [1:0] {
		SLOT_FREE   = 2'b01,
		SLOT_QUEUED = 2'b10
	} slot_state_t;
endpackage

// *** can_tx_slot.sv ***
`timescale 1ns/100ps
`default_nettype none
// one transmit slot: empty flag, abort request and abort acknowledge
module can_tx_slot
	import can_tx_flags_pkg::*;
(
	input  wire logic CLOCK,
	input  wire logic ARST_N,
	input  wire logic in_init,
	input  wire logic listen,
	input  wire logic clear_wr,
	input  wire logic abort_wr,
	input  wire logic sent_ok,
	input  wire logic aborted,
	input  wire logic tx_started,
	input  wire logic tx_failed,
	output logic      empty,
	output logic      abort_req,
	output logic      abort_ack,
	output logic      abort_grant,
	output logic      tx_start
);
	slot_state_t state_reg;
	slot_state_t state_next;
	logic        req_reg;
	logic        ack_reg;
	wire         do_clear = clear_wr && !listen && (state_reg == SLOT_QUEUED ? 1'b0 : 1'b1);
	wire         set_evt  = (state_reg == SLOT_QUEUED) && (sent_ok || abort_grant);
	// grant only before start or after a failed attempt
	assign abort_grant = req_reg && aborted && (!tx_started || tx_failed);
	assign empty       = (state_reg == SLOT_FREE);
	assign abort_req   = req_reg;
	assign abort_ack   = ack_reg;
	assign tx_start    = (state_reg == SLOT_QUEUED) && !listen;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SLOT_FREE: if (do_clear) state_next = SLOT_QUEUED;
			SLOT_QUEUED: if (set_evt) state_next = SLOT_FREE;
			default: state_next = SLOT_FREE;
		endcase
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= SLOT_FREE;
			req_reg   <= 1'b0;
			ack_reg   <= 1'b0;
		end else if (in_init) begin
			state_reg <= SLOT_FREE;
			req_reg   <= 1'b0;
			ack_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			// setting the flag drops the request, even if written now
			req_reg   <= set_evt ? 1'b0 : (req_reg || (abort_wr && state_reg == SLOT_QUEUED));
			ack_reg   <= do_clear ? 1'b0 : (ack_reg || abort_grant);
		end
	end

	chk_set_drops_req: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		set_evt && !in_init |=> empty && !abort_req)
		else $error("abort request survived flag set");
	chk_clear_drops_ack: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		do_clear && !in_init |=> !empty && !abort_ack)
		else $error("abort ack survived flag clear");
	chk_grant_sets_ack: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		abort_grant && !in_init |=> empty && abort_ack)
		else $error("granted abort did not free slot");
	chk_listen_no_start: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		listen && empty |=> empty || in_init)
		else $error("slot queued in listen mode");
endmodule
`default_nettype wire

// *** can_tx_buffer_flags.sv ***
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - bits 7..3 of flag and enable registers read zero, ignore writes
// - init mode holds flag and enable registers at reset, ignoring writes
// - writing one to an empty flag clears it; zero leaves it
// - empty flag reads one when slot free, zero when queued
// - successful send sets the slot's empty flag
// - successful abort sets the slot's empty flag
// - interrupt stays high while an empty flag and its enable are one
// - clearing an empty flag clears the slot's abort acknowledge
// - setting an empty flag clears the slot's abort request
// - listen mode: flags cannot be cleared, no transmission starts
// - queued slot blocks buffer reads and writes
// - abort granted only before start or after failed transmission
module can_tx_buffer_flags
	import can_tx_flags_pkg::*;
#(
	parameter int unsigned SLOTS = NUM_SLOTS
)(
	input  wire logic               CLOCK,
	input  wire logic               ARST_N,
	input  wire logic [ADDR_W-1:0]  AVS_ADDRESS,
	input  wire logic               AVS_READ,
	input  wire logic               AVS_WRITE,
	input  wire logic [31:0]        AVS_WRITEDATA,
	input  wire logic [3:0]         AVS_BYTEENABLE,
	output logic      [31:0]        AVS_READDATA,
	output logic                    AVS_WAITREQUEST,
	output logic      [1:0]         AVS_RESPONSE,
	input  wire logic [SLOTS-1:0]   TX_SENT_OK,
	input  wire logic [SLOTS-1:0]   TX_ABORTED,
	input  wire logic [SLOTS-1:0]   TX_STARTED,
	input  wire logic [SLOTS-1:0]   TX_FAILED,
	input  wire logic [SLOTS-1:0]   BUF_ACCESS,
	output logic      [SLOTS-1:0]   BUF_BLOCKED,
	output logic      [SLOTS-1:0]   TX_START,
	output logic                    TX_EMPTY_IRQ,
	output logic                    IRQ
);
	logic [SLOTS-1:0] irq_en_reg;
	logic [2:0]       ctrl_reg;
	logic [1:0]       sts_reg;
	logic [1:0]       mask_reg;
	logic             ack_reg;
	logic [31:0]      rdata_reg;
	logic [1:0]       resp_reg;
	logic [SLOTS-1:0] empty;
	logic [SLOTS-1:0] abort_req;
	logic [SLOTS-1:0] abort_ack;
	logic [SLOTS-1:0] abort_grant;
	logic [SLOTS-1:0] empty_d_reg;

	// one wait state: the answer is registered, request held until ack
	wire       req      = (AVS_READ || AVS_WRITE) && !ack_reg;
	// a write lands on the edge where waitrequest is seen low, not before
	wire       wr_go    = AVS_WRITE && ack_reg && AVS_BYTEENABLE[0];
	wire       init_req = ctrl_reg[CTRL_INIT_REQ];
	wire       listen   = ctrl_reg[CTRL_LISTEN];
	// acknowledge follows request after one cycle
	wire       in_init  = init_req && ctrl_reg[CTRL_INIT_ACK];
	wire       wr_ok    = wr_go && !init_req && !ctrl_reg[CTRL_INIT_ACK];
	wire       hit_flag = AVS_ADDRESS == IDX_TX_FLAG;
	wire       hit_ien  = AVS_ADDRESS == IDX_TX_IRQ_EN;
	wire       hit_areq = AVS_ADDRESS == IDX_ABORT_REQ;
	wire       hit_aack = AVS_ADDRESS == IDX_ABORT_ACK;
	wire       hit_ctrl = AVS_ADDRESS == IDX_CTRL;
	wire       hit_sts  = AVS_ADDRESS == IDX_IRQ_STATUS;
	wire       hit_mask = AVS_ADDRESS == IDX_IRQ_MASK;
	wire       mapped   = hit_flag | hit_ien | hit_areq | hit_aack | hit_ctrl | hit_sts | hit_mask;
	wire [SLOTS-1:0] clear_wr = (wr_ok && hit_flag) ? AVS_WRITEDATA[SLOTS-1:0] : '0;
	wire [SLOTS-1:0] abort_wr = (wr_ok && hit_areq) ? AVS_WRITEDATA[SLOTS-1:0] : '0;
	wire [SLOTS-1:0] txe_irq  = empty & irq_en_reg;
	wire             sent_evt = |(TX_SENT_OK & ~empty);
	wire             abrt_evt = |abort_grant;
	wire [1:0]       evt      = {abrt_evt, sent_evt};
	wire [7:0]       rd_byte  =
		hit_flag ? {5'h00, empty} :
		hit_ien  ? {5'h00, irq_en_reg} :
		hit_areq ? {5'h00, abort_req} :
		hit_aack ? {5'h00, abort_ack} :
		hit_ctrl ? {5'h00, ctrl_reg} :
		hit_sts  ? {6'h00, sts_reg} :
		hit_mask ? {6'h00, mask_reg} : 8'h00;

	genvar g;
	generate
		for (g = 0; g < SLOTS; g++) begin : gen_slot
			can_tx_slot u_slot (
				.CLOCK      (CLOCK),
				.ARST_N     (ARST_N),
				.in_init    (in_init),
				.listen     (listen),
				.clear_wr   (clear_wr[g]),
				.abort_wr   (abort_wr[g]),
				.sent_ok    (TX_SENT_OK[g]),
				.aborted    (TX_ABORTED[g]),
				.tx_started (TX_STARTED[g]),
				.tx_failed  (TX_FAILED[g]),
				.empty      (empty[g]),
				.abort_req  (abort_req[g]),
				.abort_ack  (abort_ack[g]),
				.abort_grant(abort_grant[g]),
				.tx_start   (TX_START[g])
			);
		end
	endgenerate

	assign BUF_BLOCKED     = BUF_ACCESS & ~empty;
	assign TX_EMPTY_IRQ    = |txe_irq;
	assign IRQ             = |(sts_reg & mask_reg);
	assign AVS_WAITREQUEST = req;
	assign AVS_READDATA    = rdata_reg;
	assign AVS_RESPONSE    = resp_reg;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			resp_reg  <= 2'h0;
		end else begin
			ack_reg   <= req;
			rdata_reg <= (req && AVS_READ) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			resp_reg  <= (req && !mapped) ? 2'h2 : 2'h0;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_en_reg <= IRQ_EN_RESET;
		end else if (in_init) begin
			irq_en_reg <= IRQ_EN_RESET;
		end else if (wr_ok && hit_ien) begin
			irq_en_reg <= AVS_WRITEDATA[SLOTS-1:0];
		end
	end

	// init ack follows the request with one cycle of lag
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_reg <= ZERO3;
		end else begin
			if (wr_go && hit_ctrl) begin
				ctrl_reg[CTRL_INIT_REQ] <= AVS_WRITEDATA[CTRL_INIT_REQ];
				ctrl_reg[CTRL_LISTEN]   <= AVS_WRITEDATA[CTRL_LISTEN];
			end
			ctrl_reg[CTRL_INIT_ACK] <= init_req;
		end
	end

	// sticky status: set wins over write-one-to-clear
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			sts_reg  <= 2'h0;
			mask_reg <= 2'h0;
		end else begin
			sts_reg <= evt | (sts_reg & ~((wr_go && hit_sts) ? AVS_WRITEDATA[1:0] : 2'h0));
			if (wr_go && hit_mask)
				mask_reg <= AVS_WRITEDATA[1:0];
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N)
			empty_d_reg <= FLAG_RESET;
		else
			empty_d_reg <= empty;
	end

	chk_irq_follows_en: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		TX_EMPTY_IRQ == |(empty & irq_en_reg))
		else $error("transmit empty irq wrong");
	chk_init_holds: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		in_init |=> empty == FLAG_RESET && irq_en_reg == IRQ_EN_RESET)
		else $error("init mode did not hold reset values");
	chk_reserved_zero: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		ack_reg && $past(AVS_READ) && $past(hit_flag || hit_ien) |-> AVS_READDATA[7:3] == 5'h00)
		else $error("reserved bits read nonzero");
	chk_write_clears: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		wr_ok && hit_flag && AVS_WRITEDATA[0] && !listen && empty[0] |=> !empty[0] || in_init)
		else $error("flag not cleared by one");
	chk_zero_keeps: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		empty_d_reg[0] && !empty[0] |-> $past(clear_wr[0]))
		else $error("flag cleared without a write");
	chk_sent_sets: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		TX_SENT_OK[0] && !empty[0] && !in_init |=> empty[0] ##1 sts_reg[0])
		else $error("send did not set flag");
	chk_block_queued: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		BUF_ACCESS[0] && !empty[0] |-> BUF_BLOCKED[0])
		else $error("queued slot not blocked");
	chk_abort_cond: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		abort_grant[0] |-> !TX_STARTED[0] || TX_FAILED[0])
		else $error("abort granted mid transmission");

	// bus handshake: one wait state, answer stands one cycle
	sequence seq_waiting;
		AVS_WAITREQUEST && !ack_reg;
	endsequence
	sequence seq_answered;
		!AVS_WAITREQUEST && ack_reg ##1 !ack_reg;
	endsequence

	chk_bus_one_wait: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		seq_waiting |=> seq_answered)
		else $error("bus answer not after one wait state");

	chk_wait_raised: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(AVS_READ || AVS_WRITE) && !ack_reg |-> AVS_WAITREQUEST)
		else $error("new request not held off");

	chk_no_wait_idle: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
		else $error("waitrequest high while idle");

	chk_resp_unmapped: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		req && !mapped |=> AVS_RESPONSE == 2'h2)
		else $error("unmapped access not flagged");

	chk_resp_mapped: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		req && mapped |=> AVS_RESPONSE == 2'h0)
		else $error("mapped access flagged");

	chk_rd_upper_zero: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		ack_reg && $past(AVS_READ) |-> AVS_READDATA[31:8] == 24'h00_0000)
		else $error("read data upper bytes nonzero");

	chk_flag_rd_value: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		ack_reg && $past(AVS_READ) && $past(hit_flag) |-> AVS_READDATA[2:0] == $past(empty))
		else $error("flag read does not match slots");

	chk_ien_rd_value: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		ack_reg && $past(AVS_READ) && $past(hit_ien) |-> AVS_READDATA[2:0] == $past(irq_en_reg))
		else $error("enable read does not match register");

	chk_ien_write: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		wr_ok && hit_ien |=> irq_en_reg == $past(AVS_WRITEDATA[SLOTS-1:0]))
		else $error("enable write lost");

	chk_init_no_write: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		in_init && AVS_WRITE && hit_ien |=> irq_en_reg == IRQ_EN_RESET)
		else $error("enable written in init mode");

	chk_init_ack_lag: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		ctrl_reg[CTRL_INIT_ACK] == $past(init_req))
		else $error("init ack does not follow request");

	chk_irq_mask_and: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		IRQ == |(sts_reg & mask_reg))
		else $error("irq does not follow status and mask");

	chk_sts_sticky: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		sts_reg[0] && !(wr_go && hit_sts && AVS_WRITEDATA[0]) |=> sts_reg[0])
		else $error("sent status lost without clear");

	chk_sent_status: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		sent_evt |=> sts_reg[0])
		else $error("send event not recorded");

	chk_abort_status: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		abrt_evt |=> sts_reg[1])
		else $error("abort event not recorded");

	chk_listen_keeps: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		listen && wr_ok && hit_flag |=> (empty & $past(empty)) == $past(empty))
		else $error("flag cleared in listen mode");

	chk_listen_no_tx: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		listen |-> TX_START == '0)
		else $error("transmission offered in listen mode");

	chk_start_queued: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		!listen |-> TX_START == ~empty)
		else $error("start does not match queued slots");

	chk_grant_frees: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		1'b1 |=> (empty & $past(abort_grant)) == $past(abort_grant))
		else $error("granted abort left slot queued");

	chk_sent_frees: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		1'b1 |=> (empty & $past(TX_SENT_OK & ~empty)) == $past(TX_SENT_OK & ~empty))
		else $error("sent slot left queued");

	chk_ack_cleared: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(empty_d_reg & ~empty) != '0 |-> (abort_ack & empty_d_reg & ~empty) == '0)
		else $error("abort ack kept on flag clear");

	chk_req_cleared: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		(~empty_d_reg & empty & abort_req) == '0)
		else $error("abort request kept on flag set");
endmodule
`default_nettype wire

// *** can_engine_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// behavioural protocol engine; the bench paces every step
module can_engine_model (
	input  wire logic       CLOCK,
	input  wire logic       ARST_N,
	input  wire logic [2:0] TX_START,
	input  wire logic [2:0] GO_BEGIN,
	input  wire logic [2:0] GO_FAIL,
	input  wire logic [2:0] GO_DONE,
	input  wire logic [2:0] GO_ABORT,
	output logic      [2:0] TX_STARTED,
	output logic      [2:0] TX_FAILED,
	output logic      [2:0] TX_SENT_OK,
	output logic      [2:0] TX_ABORTED
);
	// a frame only starts or ends on a slot that is really queued
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			TX_STARTED <= 3'h0;
			TX_FAILED  <= 3'h0;
			TX_SENT_OK <= 3'h0;
			TX_ABORTED <= 3'h0;
		end else begin
			TX_STARTED <= (TX_STARTED | (GO_BEGIN & TX_START)) & ~GO_DONE & ~GO_ABORT;
			TX_FAILED  <= (TX_FAILED | (GO_FAIL & TX_STARTED)) & ~GO_DONE & ~GO_ABORT;
			TX_SENT_OK <= GO_DONE & TX_START & TX_STARTED;
			TX_ABORTED <= GO_ABORT & TX_START;
		end
	end
endmodule
`default_nettype wire

// *** can_tx_buffer_flags_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module can_tx_buffer_flags_tb_top;
	import can_tx_flags_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic        wreq;
	logic [1:0]  resp;
	logic [1:0]  rsp;
	logic [31:0] q;
	logic [2:0]  sent, abrt, strt, fail, blocked, start;
	logic [2:0]  go_b = 3'h0, go_f = 3'h0, go_d = 3'h0, go_a = 3'h0, bacc = 3'h0;
	logic        tx_irq, irq;
	int          n_errors = 0;
	int          checks = 0;

	always #50 clk = ~clk;

	can_tx_buffer_flags dut (.CLOCK(clk), .ARST_N(rst_n), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(resp),
		.TX_SENT_OK(sent), .TX_ABORTED(abrt), .TX_STARTED(strt), .TX_FAILED(fail),
		.BUF_ACCESS(bacc), .BUF_BLOCKED(blocked), .TX_START(start),
		.TX_EMPTY_IRQ(tx_irq), .IRQ(irq));
	can_engine_model engine (.CLOCK(clk), .ARST_N(rst_n), .TX_START(start),
		.GO_BEGIN(go_b), .GO_FAIL(go_f), .GO_DONE(go_d), .GO_ABORT(go_a),
		.TX_STARTED(strt), .TX_FAILED(fail), .TX_SENT_OK(sent), .TX_ABORTED(abrt));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	// entered just after an edge; holds the request until waitrequest is low
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (n >= 20) chk("bus answer", 32'h0, 32'h1);
		q = rdat;
		rsp = resp;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string nm);
		acc(1'b0, a, 8'h00);
		chk(nm, {24'h0, e}, q);
	endtask

	task automatic close_out;
		$display("checks %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(IDX_TX_FLAG, 8'h07, "flags");
		acc(1'b1, IDX_TX_IRQ_EN, 8'hFF);
		rdc(IDX_TX_IRQ_EN, 8'h07, "enables");
		chk("tx irq", 32'h1, {31'h0, tx_irq});
		acc(1'b0, 6'h3F, 8'h00);
		chk("unmapped response", 32'h2, {30'h0, rsp});
		$display("test reset done");
		acc(1'b1, IDX_TX_FLAG, 8'hF9);
		acc(1'b1, IDX_TX_FLAG, 8'h00);
		rdc(IDX_TX_FLAG, 8'h06, "flags");
		bacc <= 3'h3;
		@(posedge clk);
		chk("blocked", 32'h1, {29'h0, blocked});
		chk("start", 32'h1, {29'h0, start});
		bacc <= 3'h0;
		acc(1'b1, IDX_TX_IRQ_EN, 8'h01);
		chk("tx irq", 32'h0, {31'h0, tx_irq});
		go_b <= 3'h1;
		@(posedge clk);
		go_b <= 3'h0;
		go_d <= 3'h1;
		@(posedge clk);
		go_d <= 3'h0;
		repeat (2) @(posedge clk);
		rdc(IDX_TX_FLAG, 8'h07, "flags");
		chk("tx irq", 32'h1, {31'h0, tx_irq});
		rdc(IDX_IRQ_STATUS, 8'h01, "status");
		acc(1'b1, IDX_IRQ_MASK, 8'h01);
		chk("irq", 32'h1, {31'h0, irq});
		acc(1'b1, IDX_IRQ_STATUS, 8'h01);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test send done");
		acc(1'b1, IDX_TX_FLAG, 8'h02);
		acc(1'b1, IDX_ABORT_REQ, 8'h02);
		rdc(IDX_ABORT_REQ, 8'h02, "abort req");
		go_a <= 3'h2;
		@(posedge clk);
		go_a <= 3'h0;
		repeat (2) @(posedge clk);
		rdc(IDX_TX_FLAG, 8'h07, "flags");
		rdc(IDX_ABORT_ACK, 8'h02, "abort ack");
		rdc(IDX_ABORT_REQ, 8'h00, "abort req");
		acc(1'b1, IDX_TX_FLAG, 8'h02);
		rdc(IDX_ABORT_ACK, 8'h00, "abort ack");
		$display("test abort done");
		acc(1'b1, IDX_CTRL, 8'h02);
		acc(1'b1, IDX_TX_FLAG, 8'h04);
		rdc(IDX_TX_FLAG, 8'h05, "flags");
		chk("start", 32'h0, {29'h0, start});
		acc(1'b1, IDX_CTRL, 8'h01);
		repeat (2) @(posedge clk);
		acc(1'b1, IDX_TX_IRQ_EN, 8'h07);
		rdc(IDX_TX_IRQ_EN, 8'h00, "enables");
		rdc(IDX_TX_FLAG, 8'h07, "flags");
		$display("test modes done");
		close_out();
	end
endmodule
`default_nettype wire
